// *** core/pc_return_stack.sv ***
// Purpose: Two-level return stack storage
// Assumes: Push and pop never asserted together
// Notes: No reset; contents survive every reset of the core
`timescale 1ns/10ps
module pc_return_stack
  import pc_stack_pkg::*;
(
  // Clock
  input wire logic mclk_in,
  // Control
  input wire logic push_in,
  input wire logic pop_in,
  input wire logic [STACK_W-1:0] push_data_in,
  // Levels
  output logic [STACK_W-1:0] level1_out,
  output logic [STACK_W-1:0] level2_out
);

  typedef struct packed {
    logic [STACK_W-1:0] level1;
    logic [STACK_W-1:0] level2;
  } stack_state_type;

  stack_state_type s_r;
  stack_state_type s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (push_in) begin
      s_nxt.level2 = s_r.level1; // RULE_09
      s_nxt.level1 = push_data_in; // RULE_09
    end else if (pop_in) begin
      // Level two keeps its value so repeated pops replay it
      s_nxt.level1 = s_r.level2; // RULE_10 RULE_11
    end
  end

  always_ff @(posedge mclk_in) begin
    s_r <= s_nxt; // RULE_13
  end

  assign level1_out = s_r.level1;
  assign level2_out = s_r.level2;

endmodule : pc_return_stack

// *** core/pc_stack_indirect_addr.sv ***
// Purpose: Program counter, return stack and indirect data addressing
// Assumes: Each clock edge is one instruction cycle while run is set
// Notes: Registers on Avalon-MM, one wait cycle per access
//
// Summary of operation
// RULE_01: PC advances by one each cycle unless the instruction loads it.
// RULE_02: Jump loads PC bits 8:0 from the instruction immediate.
// RULE_03: PC bit 9 comes from status page bit 5 on branch loads.
// RULE_04: Low eight PC bits are readable and writable as a data register.
// RULE_05: Call or low-latch write loads PC 7:0 from result, clears bit 8.
// RULE_06: Reset puts PC at the last location so it wraps to zero.
// RULE_07: Reset clears the status page bits, selecting page zero.
// RULE_08: Return stack is last-in first-out with 12-bit entries.
// RULE_09: Call copies level one to two, then pushes PC plus one.
// RULE_10: Return-with-literal loads PC from level one, copies two to one.
// RULE_11: Excess returns keep supplying the level two address.
// RULE_12: Return-with-literal also loads the working register with its literal.
// RULE_13: Reset leaves both stack levels unchanged.
// RULE_14: No overflow or underflow flag exists for the stack.
// RULE_15: Indirect port accesses go to the location held in the pointer.
// RULE_16: Indirect read with pointer zero returns zero.
// RULE_17: Indirect write with pointer zero changes no data location.
// RULE_18: Pointer bits 4:0 select data addresses 00h to 1Fh.
// RULE_19: Unbanked variant reads the upper three pointer bits as ones.
// RULE_20: Banked variant uses pointer bit 5 for bank, bits 7:6 read ones.
// RULE_21: PC is ten bits and wraps from all ones to zero.
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/10ps
module pc_stack_indirect_addr
  import pc_stack_pkg::*;
#(
  parameter bit BANKED = 1'b1
)
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Decoder side
  input wire op_type op_in,
  input wire file_req_type file_req_in,
  // Core outputs
  output logic [PC_W-1:0] pc_out,
  output logic w_load_out,
  output logic [DATA_W-1:0] w_literal_out,
  output logic file_rvalid_out,
  output logic [DATA_W-1:0] file_rdata_out,
  // Data memory side
  output mem_req_type mem_req_out,
  // Avalon-MM slave
  input wire logic [AV_ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [AV_DATA_W-1:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [AV_DATA_W-1:0] avs_readdata_out,
  output logic avs_waitrequest_out
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic [DATA_W-1:0] status;
    logic [DATA_W-1:0] pointer;
    logic run;
    logic w_load;
    logic [DATA_W-1:0] w_literal;
    logic file_rvalid;
    logic [DATA_W-1:0] file_rdata;
    mem_req_type mem_req;
    logic [AV_DATA_W-1:0] av_rdata;
    logic av_wait;
  } state_type;

  localparam state_type STATE_RESET = '{
    pc: PC_RESET,
    status: STATUS_RESET,
    pointer: POINTER_RESET,
    run: CTRL_RUN_RESET,
    w_load: 1'b0,
    w_literal: '0,
    file_rvalid: 1'b0,
    file_rdata: '0,
    mem_req: '0,
    av_rdata: '0,
    av_wait: 1'b1
  };

  state_type s_r;
  state_type s_nxt;

  logic stack_push;
  logic stack_pop;
  logic [STACK_W-1:0] stack_push_data;
  logic [STACK_W-1:0] stack_level1;
  logic [STACK_W-1:0] stack_level2;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Pointer as software and the core see it
  function automatic logic [DATA_W-1:0] pointer_view(input logic [DATA_W-1:0] ptr);
    if (BANKED) begin
      pointer_view = ptr | PTR_ONES_BANKED; // RULE_20
    end else begin
      pointer_view = ptr | PTR_ONES_FLAT; // RULE_19
    end
  endfunction : pointer_view

  // Branch target with page bit on top and given bit 8 and low byte
  function automatic logic [PC_W-1:0] branch_target(
    input logic page,
    input logic bit8,
    input logic [7:0] low
  );
    branch_target = {page, bit8, low}; // RULE_03
  endfunction : branch_target

  // Data memory address for a resolved file address
  function automatic logic [MADDR_W-1:0] mem_address(
    input logic [DATA_W-1:0] ptr,
    input logic [FADDR_W-1:0] fa
  );
    logic bank;
    bank = BANKED & ptr[POINTER_BANK_BIT];
    mem_address = {bank, fa}; // RULE_18 RULE_20
  endfunction : mem_address

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic page;
    logic indirect;
    logic self_ref;
    logic [FADDR_W-1:0] eff;
    logic [DATA_W-1:0] rd_val;
    logic av_take;
    logic av_start;
    s_nxt = s_r;
    page = 1'b0;
    indirect = 1'b0;
    self_ref = 1'b0;
    eff = '0;
    rd_val = '0;
    av_take = 1'b0;
    av_start = 1'b0;
    stack_push = 1'b0;
    stack_pop = 1'b0;
    stack_push_data = '0;
    s_nxt.w_load = 1'b0;
    s_nxt.file_rvalid = 1'b0;
    s_nxt.mem_req = '0;

    page = s_r.status[STATUS_PAGE_BIT];
    indirect = (file_req_in.addr == FA_INDIRECT);
    eff = indirect ? s_r.pointer[FADDR_W-1:0] : file_req_in.addr; // RULE_15 RULE_18
    self_ref = indirect && (eff == FA_INDIRECT);

    if (s_r.run) begin
      s_nxt.pc = s_r.pc + 1'b1; // RULE_01 RULE_21
      case (op_in.kind)
        OP_JUMP: begin
          s_nxt.pc = branch_target(page, op_in.imm[8], op_in.imm[7:0]); // RULE_02 RULE_03
        end
        OP_CALL: begin
          stack_push = 1'b1; // RULE_09
          stack_push_data = STACK_W'(s_r.pc + 1'b1); // RULE_08 RULE_09
          s_nxt.pc = branch_target(page, 1'b0, op_in.imm[7:0]); // RULE_05
        end
        OP_RETURN_WITH_LITERAL: begin
          // Empty stack is not flagged; level two simply repeats
          stack_pop = 1'b1; // RULE_10 RULE_11 RULE_14
          s_nxt.pc = stack_level1[PC_W-1:0]; // RULE_10
          s_nxt.w_load = 1'b1; // RULE_12
          s_nxt.w_literal = op_in.literal; // RULE_12
        end
        OP_SEQ: begin
          s_nxt.pc = s_r.pc + 1'b1; // RULE_01
        end
        default: begin
          s_nxt.pc = s_r.pc + 1'b1;
        end
      endcase

      // Core file write
      if (file_req_in.wr && !self_ref) begin // RULE_17
        if (eff == FA_PC_LOW) begin
          s_nxt.pc = branch_target(page, 1'b0, file_req_in.wdata); // RULE_04 RULE_05
        end else if (eff == FA_STATUS) begin
          s_nxt.status = file_req_in.wdata;
        end else if (eff == FA_POINTER) begin
          s_nxt.pointer = file_req_in.wdata;
        end else begin
          s_nxt.mem_req.wr = 1'b1; // RULE_15
          s_nxt.mem_req.addr = mem_address(s_r.pointer, eff);
          s_nxt.mem_req.wdata = file_req_in.wdata;
        end
      end

      // Core file read
      if (file_req_in.rd) begin
        if (self_ref) begin
          s_nxt.file_rvalid = 1'b1;
          s_nxt.file_rdata = '0; // RULE_16
        end else if (eff == FA_PC_LOW) begin
          s_nxt.file_rvalid = 1'b1;
          s_nxt.file_rdata = s_r.pc[7:0]; // RULE_04
        end else if (eff == FA_STATUS) begin
          s_nxt.file_rvalid = 1'b1;
          s_nxt.file_rdata = s_r.status;
        end else if (eff == FA_POINTER) begin
          s_nxt.file_rvalid = 1'b1;
          s_nxt.file_rdata = pointer_view(s_r.pointer); // RULE_19 RULE_20
        end else begin
          s_nxt.mem_req.rd = 1'b1; // RULE_15
          s_nxt.mem_req.addr = mem_address(s_r.pointer, eff);
        end
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Avalon slave: one wait cycle, then the access completes

    av_start = (avs_read_in || avs_write_in) && s_r.av_wait;
    av_take = (avs_read_in || avs_write_in) && !s_r.av_wait;
    s_nxt.av_wait = !av_start;

    if (av_start && avs_read_in) begin
      case (avs_address_in)
        REG_PC: rd_val = s_r.pc[7:0];
        REG_STATUS: rd_val = s_r.status;
        REG_POINTER: rd_val = pointer_view(s_r.pointer);
        default: rd_val = '0;
      endcase
      case (avs_address_in)
        REG_PC: s_nxt.av_rdata = AV_DATA_W'(s_r.pc);
        REG_STATUS, REG_POINTER: s_nxt.av_rdata = AV_DATA_W'(rd_val);
        REG_CONTROL: s_nxt.av_rdata = AV_DATA_W'(s_r.run);
        REG_STACK1: s_nxt.av_rdata = AV_DATA_W'(stack_level1);
        REG_STACK2: s_nxt.av_rdata = AV_DATA_W'(stack_level2);
        default: s_nxt.av_rdata = '0;
      endcase
    end

    // Bus writes take priority over a same-cycle core write
    if (av_take && avs_write_in && avs_byteenable_in[0]) begin
      case (avs_address_in)
        REG_STATUS: s_nxt.status = avs_writedata_in[DATA_W-1:0];
        REG_POINTER: s_nxt.pointer = avs_writedata_in[DATA_W-1:0];
        REG_CONTROL: s_nxt.run = avs_writedata_in[CTRL_RUN_BIT];
        default: s_nxt.run = s_r.run;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      s_r <= STATE_RESET; // RULE_06 RULE_07
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Return stack, not touched by reset

  pc_return_stack u_stack (
    .mclk_in(mclk_in),
    .push_in(stack_push),
    .pop_in(stack_pop),
    .push_data_in(stack_push_data),
    .level1_out(stack_level1),
    .level2_out(stack_level2)
  ); // RULE_08 RULE_13

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign pc_out = s_r.pc;
  assign w_load_out = s_r.w_load;
  assign w_literal_out = s_r.w_literal;
  assign file_rvalid_out = s_r.file_rvalid;
  assign file_rdata_out = s_r.file_rdata;
  assign mem_req_out = s_r.mem_req;
  assign avs_readdata_out = s_r.av_rdata;
  assign avs_waitrequest_out = s_r.av_wait;

endmodule : pc_stack_indirect_addr

// *** pkg/pc_stack_pkg.sv ***
// Purpose: Shared constants and carriers for the sequencing and addressing block
// Assumes: Avalon-MM word addressing, 32-bit data, one register per word
// Notes: Register byte address is four times the register index
package pc_stack_pkg;

  // Widths
  localparam int PC_W = 10;
  localparam int STACK_W = 12;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 5;
  localparam int MADDR_W = 6;
  localparam int AV_ADDR_W = 4;
  localparam int AV_DATA_W = 32;

  // Reset values
  localparam logic [PC_W-1:0] PC_RESET = 10'h3FF;
  localparam logic [DATA_W-1:0] STATUS_RESET = 8'h18;
  localparam logic [DATA_W-1:0] POINTER_RESET = 8'h00;
  localparam logic CTRL_RUN_RESET = 1'b1;

  // Field positions
  localparam int STATUS_PAGE_BIT = 5;
  localparam int POINTER_BANK_BIT = 5;
  localparam int CTRL_RUN_BIT = 0;

  // Unimplemented pointer bits read as ones
  localparam logic [DATA_W-1:0] PTR_ONES_FLAT = 8'hE0;
  localparam logic [DATA_W-1:0] PTR_ONES_BANKED = 8'hC0;

  // Data file addresses seen by the core
  localparam logic [FADDR_W-1:0] FA_INDIRECT = 5'h00;
  localparam logic [FADDR_W-1:0] FA_PC_LOW = 5'h02;
  localparam logic [FADDR_W-1:0] FA_STATUS = 5'h03;
  localparam logic [FADDR_W-1:0] FA_POINTER = 5'h04;

  // Avalon register indices
  localparam logic [AV_ADDR_W-1:0] REG_PC = 4'h2;
  localparam logic [AV_ADDR_W-1:0] REG_STATUS = 4'h3;
  localparam logic [AV_ADDR_W-1:0] REG_POINTER = 4'h4;
  localparam logic [AV_ADDR_W-1:0] REG_CONTROL = 4'h8;
  localparam logic [AV_ADDR_W-1:0] REG_STACK1 = 4'h9;
  localparam logic [AV_ADDR_W-1:0] REG_STACK2 = 4'hA;

  typedef enum logic [1:0] {
    OP_SEQ,
    OP_JUMP,
    OP_CALL,
    OP_RETURN_WITH_LITERAL
  } op_kind_type;

  // Decoded instruction from the decoder
  typedef struct packed {
    op_kind_type kind;
    logic [8:0] imm;
    logic [DATA_W-1:0] literal;
  } op_type;

  // Data file access from the core
  typedef struct packed {
    logic rd;
    logic wr;
    logic [FADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } file_req_type;

  // Request to the data memory
  typedef struct packed {
    logic rd;
    logic wr;
    logic [MADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mem_req_type;

endpackage : pc_stack_pkg

// *** sim/data_mem_model.sv ***
// Purpose: Data memory standing behind the block
// Assumes: At most one access per cycle from the block
// Notes: Read data return lies outside the block, so reads only address a cell
`timescale 1ns/10ps
module data_mem_model
  import pc_stack_pkg::*;
(
  // Clock
  input wire logic mclk_in,
  // Requests
  input wire mem_req_type mem_req_in
);
  logic [DATA_W-1:0] cells [2**MADDR_W];
  // Bank bit and five address bits pick one cell
  always @(posedge mclk_in) begin
    if (mem_req_in.wr === 1'b1) begin
      cells[mem_req_in.addr] <= mem_req_in.wdata;
    end
  end
endmodule : data_mem_model

// *** sim/pc_stack_checker.sv ***
// Purpose: Port-level assertions for the sequencing block
// Assumes: One clock, asynchronous active-high reset
// Notes: Run bit is followed from completed bus writes
`timescale 1ns/10ps
module pc_stack_checker
  import pc_stack_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Core side
  input wire op_type op_in,
  input wire file_req_type file_req_in,
  input wire logic [PC_W-1:0] pc_out,
  input wire logic w_load_out,
  input wire logic [DATA_W-1:0] w_literal_out,
  input wire logic file_rvalid_out,
  input wire logic [DATA_W-1:0] file_rdata_out,
  input wire mem_req_type mem_req_out,
  // Bus
  input wire logic [AV_ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [AV_DATA_W-1:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [AV_DATA_W-1:0] avs_readdata_out,
  input wire logic avs_waitrequest_out
);
  logic run_r;
  logic run_nxt;
  logic ready_r;
  logic live;
  logic act;
  // Attempts start two edges after reset release, once pc has left the reset vector
  assign live = run_r && ready_r;
  assign act = live && !file_req_in.wr;
  always_comb begin
    run_nxt = run_r;
    if (avs_write_in && !avs_waitrequest_out && avs_address_in == REG_CONTROL
        && avs_byteenable_in[0]) begin
      run_nxt = avs_writedata_in[CTRL_RUN_BIT];
    end
  end
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) run_r <= CTRL_RUN_RESET;
    else run_r <= run_nxt;
  end
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) ready_r <= 1'b0;
    else ready_r <= 1'b1;
  end
  //////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  a_seq_advance: assert property (act && op_in.kind == OP_SEQ |=>
    pc_out == $past(pc_out) + 10'h001) else $error("pc did not advance");
  a_jump_load: assert property (act && op_in.kind == OP_JUMP |=>
    pc_out[8:0] == $past(op_in.imm)) else $error("jump target wrong");
  a_call_load: assert property (act && op_in.kind == OP_CALL |=>
    pc_out[8:0] == {1'b0, $past(op_in.imm[7:0])}) else $error("call target wrong");
  a_pclow_write: assert property (live && file_req_in.wr &&
    file_req_in.addr == FA_PC_LOW |=> pc_out[8:0] == {1'b0, $past(file_req_in.wdata)})
    else $error("pc low write wrong");
  a_return_with_literal_literal: assert property (live && op_in.kind == OP_RETURN_WITH_LITERAL |=>
    w_load_out && w_literal_out == $past(op_in.literal)) else $error("literal not loaded");
  a_wload_cause: assert property (w_load_out |->
    $past(op_in.kind) == OP_RETURN_WITH_LITERAL && $past(run_r)) else $error("stray literal load");
  a_mem_direct: assert property (mem_req_out.rd &&
    $past(file_req_in.addr) != FA_INDIRECT |->
    mem_req_out.addr[4:0] == $past(file_req_in.addr)) else $error("memory address wrong");
  a_mem_wdata: assert property (mem_req_out.wr |->
    mem_req_out.wdata == $past(file_req_in.wdata)) else $error("memory write data wrong");
  a_reset_vector: assert property ($past(rst_in) |-> pc_out == PC_RESET)
    else $error("reset vector wrong");
  c_literal: cover property (w_load_out);
  c_mem_write: cover property (mem_req_out.wr);
  c_file_answer: cover property (file_rvalid_out);
  c_run_stopped: cover property (!run_r && op_in.kind == OP_JUMP);
endmodule : pc_stack_checker

bind pc_stack_indirect_addr pc_stack_checker i_pc_stack_checker (
  .mclk_in(mclk_in), .rst_in(rst_in), .op_in(op_in), .file_req_in(file_req_in),
  .pc_out(pc_out), .w_load_out(w_load_out), .w_literal_out(w_literal_out),
  .file_rvalid_out(file_rvalid_out), .file_rdata_out(file_rdata_out),
  .mem_req_out(mem_req_out), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
  .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out)
);

// *** sim/pc_stack_indirect_addr_bench.sv ***
// Purpose: Self-checking bench for the sequencing block
// Assumes: Banked variant, run bit set apart from one stopped stretch
// Notes: Expected core outputs are queued and matched by a monitor
`timescale 1ns/10ps
module pc_stack_indirect_addr_bench;
  import pc_stack_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  op_type op_in = '0;
  file_req_type file_req_in = '0;
  logic [3:0] avs_address_in = 4'h0;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0000_0000;
  logic [3:0] avs_byteenable_in = 4'hF;
  logic [PC_W-1:0] pc_out;
  logic w_load_out;
  logic [7:0] w_literal_out;
  logic file_rvalid_out;
  logic [7:0] file_rdata_out;
  mem_req_type mem_req_out;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [15:0] notes [$];
  logic [9:0] epc;
  logic [31:0] q;
  logic [11:0] s1;
  logic [11:0] s2;
  logic [8:0] imm;
  logic [7:0] r;
  logic [4:0] a;

  always #2 mclk_in = ~mclk_in;

  pc_stack_indirect_addr i_pc_stack_indirect_addr (
    .mclk_in(mclk_in), .rst_in(rst_in), .op_in(op_in), .file_req_in(file_req_in),
    .pc_out(pc_out), .w_load_out(w_load_out), .w_literal_out(w_literal_out),
    .file_rvalid_out(file_rvalid_out), .file_rdata_out(file_rdata_out),
    .mem_req_out(mem_req_out), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out)
  );
  data_mem_model i_data_mem_model (.mclk_in(mclk_in), .mem_req_in(mem_req_out));
  //////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic take(input logic [15:0] seen);
    if (notes.size() == 0) check({16'h0000, seen}, 32'h0001_0000);
    else check({16'h0000, seen}, {16'h0000, notes.pop_front()});
  endtask : take

  task automatic print_verdict();
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  function automatic file_req_type fr(logic rd, logic wr, logic [4:0] ad, logic [7:0] d);
    return '{rd, wr, ad, d};
  endfunction : fr

  // One idle edge, then one op edge; ends settled with inputs idle
  task automatic step(input op_kind_type k, input logic [8:0] i, input logic [7:0] l,
                      input file_req_type f);
    @(posedge mclk_in);
    epc = epc + 10'h001;
    op_in <= '{k, i, l};
    file_req_in <= f;
    @(posedge mclk_in);
    op_in <= '0;
    file_req_in <= '0;
    @(negedge mclk_in);
  endtask : step

  task automatic bus(input logic w, input logic [3:0] ad, input logic [31:0] d,
                     input logic [3:0] be);
    @(posedge mclk_in);
    epc = epc + 10'h001;
    avs_address_in <= ad;
    avs_read_in <= !w;
    avs_write_in <= w;
    avs_writedata_in <= d;
    avs_byteenable_in <= be;
    do begin
      @(posedge mclk_in);
      epc = epc + 10'h001;
    end while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    @(negedge mclk_in);
  endtask : bus
  //////////////////////////////////////////////////////////////////
  always @(negedge mclk_in) begin
    if (rst_in === 1'b0) begin
      if (w_load_out === 1'b1) take({8'h10, w_literal_out});
      if (file_rvalid_out === 1'b1) take({8'h20, file_rdata_out});
      if (mem_req_out.rd === 1'b1) take({2'b10, mem_req_out.addr, 8'h00});
      if (mem_req_out.wr === 1'b1) take({2'b11, mem_req_out.addr, mem_req_out.wdata});
    end
  end

  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      print_verdict();
    end
  end

  initial begin
    void'($urandom(32'h2b44));
    repeat (10) @(posedge mclk_in);
    check(pc_out, PC_RESET);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    @(negedge mclk_in);
    epc = 10'h000;
    check(pc_out, epc);
    bus(1'b0, REG_STATUS, 32'h0000_0000, 4'hF);
    check(q[5], 1'b0);
    step(OP_SEQ, 9'h000, 8'h00, '0);
    epc = epc + 10'h001;
    check(pc_out, epc);
    for (int pg = 0; pg < 2; pg++) begin
      bus(1'b1, REG_STATUS, {26'h0, pg[0], 5'h18}, 4'hF);
      imm = 9'($urandom);
      step(OP_JUMP, imm, 8'h00, '0);
      epc = {pg[0], imm};
      check(pc_out, epc);
      check(pc_out[9], pg[0]);
    end
    step(OP_JUMP, 9'h1FF, 8'h00, '0);
    epc = 10'h3FF;
    step(OP_SEQ, 9'h000, 8'h00, '0);
    epc = epc + 10'h001;
    check(pc_out, epc);
    step(OP_CALL, 9'h155, 8'h00, '0);
    s2 = {2'b00, 10'(epc + 10'h001)};
    epc = 10'h255;
    check(pc_out, epc);
    step(OP_CALL, 9'h0AA, 8'h00, '0);
    s1 = {2'b00, 10'(epc + 10'h001)};
    epc = 10'h2AA;
    bus(1'b0, REG_STACK2, 32'h0000_0000, 4'hF);
    check(q, {20'h0_0000, s2});
    step(OP_CALL, 9'h033, 8'h00, '0);
    s2 = s1;
    s1 = {2'b00, 10'(epc + 10'h001)};
    bus(1'b0, REG_STACK1, 32'h0000_0000, 4'hF);
    check(q, {20'h0_0000, s1});
    for (int i = 0; i < 3; i++) begin
      r = 8'($urandom);
      notes.push_back({8'h10, r});
      step(OP_RETURN_WITH_LITERAL, 9'h000, r, '0);
      epc = (i == 0) ? s1[9:0] : s2[9:0];
      check(pc_out, epc);
    end
    @(posedge mclk_in);
    rst_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    @(negedge mclk_in);
    epc = 10'h000;
    check(pc_out, epc);
    bus(1'b0, REG_STACK2, 32'h0000_0000, 4'hF);
    check(q, {20'h0_0000, s2});
    step(OP_JUMP, 9'h1FF, 8'h00, '0);
    check(pc_out, 10'h1FF);
    r = 8'($urandom);
    step(OP_SEQ, 9'h000, 8'h00, fr(1'b0, 1'b1, FA_PC_LOW, r));
    epc = {2'b00, r};
    check(pc_out, epc);
    // Stopped core: pc holds and ops are ignored
    bus(1'b1, REG_CONTROL, 32'h0000_0000, 4'hF);
    s1 = {2'b00, epc};
    step(OP_JUMP, 9'h0F0, 8'h00, '0);
    check(pc_out, s1);
    bus(1'b0, REG_PC, 32'h0000_0000, 4'hF);
    check(q, {20'h0_0000, s1});
    bus(1'b0, REG_CONTROL, 32'h0000_0000, 4'hF);
    check(q, 32'h0000_0000);
    bus(1'b1, REG_CONTROL, 32'h0000_0001, 4'hF);
    bus(1'b1, REG_STATUS, 32'h0000_0038, 4'h0);
    bus(1'b0, 4'hF, 32'h0000_0000, 4'hF);
    check(q, 32'h0000_0000);
    notes.push_back({8'h20, STATUS_RESET});
    step(OP_SEQ, 9'h000, 8'h00, fr(1'b1, 1'b0, FA_STATUS, 8'h00));
    step(OP_SEQ, 9'h000, 8'h00, fr(1'b0, 1'b1, FA_POINTER, 8'h27));
    bus(1'b0, REG_POINTER, 32'h0000_0000, 4'hF);
    check(q, {24'h00_0000, 8'h27 | PTR_ONES_BANKED});
    notes.push_back({2'b10, 6'h27, 8'h00});
    step(OP_SEQ, 9'h000, 8'h00, fr(1'b1, 1'b0, FA_INDIRECT, 8'h00));
    for (int i = 0; i < 4; i++) begin
      a = 5'(5 + $urandom % 27);
      r = 8'($urandom);
      notes.push_back({1'b1, ~i[0], 1'b1, a, i[0] ? 8'h00 : r});
      step(OP_SEQ, 9'h000, 8'h00, fr(i[0], ~i[0], a, r));
    end
    step(OP_SEQ, 9'h000, 8'h00, fr(1'b0, 1'b1, FA_POINTER, 8'h00));
    notes.push_back({8'h20, 8'h00});
    step(OP_SEQ, 9'h000, 8'h00, fr(1'b1, 1'b0, FA_INDIRECT, 8'h00));
    step(OP_SEQ, 9'h000, 8'h00, fr(1'b0, 1'b1, FA_INDIRECT, 8'h5A));
    repeat (2) @(posedge mclk_in);
    check(notes.size(), 0);
    print_verdict();
  end
endmodule : pc_stack_indirect_addr_bench
